// *** dfd_regs.svh ***
// register map, field positions, type codes and vector numbers
// of the descriptor and fault decode block; included by the package
`ifndef DFD_REGS_SVH
`define DFD_REGS_SVH

// register offsets on the plain register port
`define DFD_ADDR_W 4
`define DFD_OFF_CTRL 4'h0
`define DFD_OFF_STATUS 4'h4
`define DFD_OFF_MASK 4'h8
`define DFD_OFF_LAST 4'hc

// control register bits and reset values
`define DFD_CTRL_SIZE_EXT 0
`define DFD_CTRL_ALIGN_MASK 1
`define DFD_CTRL_RST 2'h0
`define DFD_MASK_RST 4'h0

// status and mask bits
`define DFD_ST_W 4
`define DFD_ST_VEC 0
`define DFD_ST_DOUBLE 1
`define DFD_ST_NMI 2
`define DFD_ST_XFER 3

// paging entry fields
`define DFD_PG_PRESENT 0
`define DFD_PG_WRITE 1
`define DFD_PG_USER 2
`define DFD_PG_WTHRU 3
`define DFD_PG_CDIS 4
`define DFD_PG_ACC 5
`define DFD_PG_LARGE 7
`define DFD_PG_SW_HI 11
`define DFD_PG_SW_LO 9

// application descriptor type bits
`define DFD_DT_ACC 0
`define DFD_DT_RW 1
`define DFD_DT_EXP 2
`define DFD_DT_CODE 3

// system segment and gate type codes
`define DFD_SYS_TASK16_FREE 4'h1
`define DFD_SYS_LOCAL_TABLE 4'h2
`define DFD_SYS_TASK16_BUSY 4'h3
`define DFD_SYS_CALL16 4'h4
`define DFD_SYS_TASK_GATE 4'h5
`define DFD_SYS_INT16 4'h6
`define DFD_SYS_TRAP16 4'h7
`define DFD_SYS_TASK32_FREE 4'h9
`define DFD_SYS_TASK32_BUSY 4'hb
`define DFD_SYS_CALL32 4'hc
`define DFD_SYS_INT32 4'he
`define DFD_SYS_TRAP32 4'hf

// vector numbers
`define DFD_V_DIVIDE 8'h00
`define DFD_V_DEBUG 8'h01
`define DFD_V_NMI 8'h02
`define DFD_V_BREAK 8'h03
`define DFD_V_OVERFLOW 8'h04
`define DFD_V_BOUND 8'h05
`define DFD_V_OPCODE 8'h06
`define DFD_V_NO_DEVICE 8'h07
`define DFD_V_DOUBLE 8'h08
`define DFD_V_BAD_TASK 8'h0a
`define DFD_V_NOT_PRESENT 8'h0b
`define DFD_V_STACK 8'h0c
`define DFD_V_PROTECT 8'h0d
`define DFD_V_PAGE 8'h0e
`define DFD_V_FLOAT 8'h10
`define DFD_V_ALIGN 8'h11

`endif

// *** dfd_pkg.sv ***
// types shared by the descriptor and fault decode block and its users
// assumes dfd_regs.svh sits in the include path
package dfd_pkg;
`include "dfd_regs.svh"

   // decoded paging entry
   typedef struct packed {
      logic present;
      logic writable;
      logic user;
      logic write_through;
      logic page_cache_disable_flag;
      logic accessed;
      logic large_page_flag;
      logic [2:0] software_available_bits;
   } dfd_page_t;

   // decoded application descriptor type
   typedef struct packed {
      logic is_code;
      logic writable;
      logic readable;
      logic expand_down;
      logic conforming;
      logic accessed;
   } dfd_app_t;

   // decoded system descriptor or gate type
   typedef enum logic [3:0] {
      DFD_SK_RESERVED,
      DFD_SK_TASK16_FREE,
      DFD_SK_TASK16_BUSY,
      DFD_SK_LOCAL_TABLE,
      DFD_SK_TASK32_FREE,
      DFD_SK_TASK32_BUSY,
      DFD_SK_CALL16,
      DFD_SK_CALL32,
      DFD_SK_TASK_GATE,
      DFD_SK_INT16,
      DFD_SK_INT32,
      DFD_SK_TRAP16,
      DFD_SK_TRAP32
   } dfd_sys_kind_t;

   // one-cycle fault and interrupt conditions from the core
   typedef struct packed {
      logic divide_err;
      logic debug_hit;
      logic breakpoint;
      logic overflow;
      logic bound_err;
      logic bad_opcode;
      logic no_device;
      logic bad_task_seg;
      logic seg_load;
      logic seg_present;
      logic stack_limit;
      logic stack_ref;
      logic stack_present;
      logic misc_protect;
      logic page_ref;
      logic page_violation;
      logic float_err;
      logic unaligned;
   } dfd_fault_t;

   typedef enum logic {
      DFD_IDLE,
      DFD_DELIVER
   } dfd_state_t;
endpackage

// *** dfd_decode.sv ***
// descriptor, paging entry and fault vector decode for the core
// assumes one core clock, a synchronous reset, and a dispatcher that
// pulses deliver_done once the handler of a raised vector has started
// limitation: nmi_pin is asynchronous, so vector 2 follows its rising
// edge by three cycles
`timescale 1ns/1ns
module dfd_decode
   import dfd_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [`DFD_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   input wire logic entry_load,
   input wire logic [31:0] entry_data,
   input wire logic entry_from_dir,
   output dfd_page_t page_fields,
   output logic large_page_path,
   output logic small_page_path,
   output logic page_valid,
   input wire logic desc_load,
   input wire logic desc_is_app,
   input wire logic [3:0] desc_type,
   output dfd_app_t app_fields,
   output dfd_sys_kind_t sys_kind,
   output logic desc_valid,
   input wire logic xfer_req,
   input wire logic [1:0] xfer_cur_pl,
   input wire logic [1:0] xfer_tgt_pl,
   input wire logic xfer_via_gate,
   output logic xfer_ok,
   output logic xfer_done,
   input wire dfd_fault_t fault_in,
   input wire logic nmi_pin,
   input wire logic alignment_check_flag,
   input wire logic soft_int,
   input wire logic [7:0] soft_vec,
   input wire logic deliver_done,
   output logic vec_valid,
   output logic [7:0] vec_num,
   output logic delivering
);

   logic [1:0] ctrl_reg;
   logic [`DFD_ST_W-1:0] status_reg;
   logic [`DFD_ST_W-1:0] mask_reg;
   logic [`DFD_ST_W-1:0] event_set;
   logic [7:0] last_vec_reg;
   logic nmi_meta;
   logic nmi_sync;
   logic nmi_seen;
   logic nmi_rise;
   logic xfer_refused;
   logic hw_hit;
   logic [7:0] hw_vec;
   logic take_double;
   logic [7:0] vec_next;
   logic raise;
   dfd_state_t state_reg;
   dfd_page_t page_next;
   dfd_app_t app_next;
   dfd_sys_kind_t kind_next;

   wire logic page_size_extension_control = ctrl_reg[`DFD_CTRL_SIZE_EXT];
   wire logic alignment_mask_bit = ctrl_reg[`DFD_CTRL_ALIGN_MASK];

   // nmi pin crossing: first stage feeds only the second
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         nmi_meta <= 1'b0;
         nmi_sync <= 1'b0;
         nmi_seen <= 1'b0;
      end else begin
         nmi_meta <= nmi_pin;
         nmi_sync <= nmi_meta;
         nmi_seen <= nmi_sync;
      end
   end

   // edge, so a long nmi level raises the vector once
   assign nmi_rise = nmi_sync & ~nmi_seen;

   // paging entry field split
   always_comb begin
      page_next.present = entry_data[`DFD_PG_PRESENT];
      page_next.writable = entry_data[`DFD_PG_WRITE];
      page_next.user = entry_data[`DFD_PG_USER];
      page_next.write_through = entry_data[`DFD_PG_WTHRU];
      page_next.page_cache_disable_flag = entry_data[`DFD_PG_CDIS];
      page_next.accessed = entry_data[`DFD_PG_ACC];
      page_next.large_page_flag = entry_data[`DFD_PG_LARGE];
      page_next.software_available_bits =
         entry_data[`DFD_PG_SW_HI:`DFD_PG_SW_LO];
   end

   // latched paging decode and path choice
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         page_fields <= '0;
         large_page_path <= 1'b0;
         small_page_path <= 1'b0;
         page_valid <= 1'b0;
      end else begin
         page_valid <= entry_load;
         if (entry_load) begin
            page_fields <= page_next;
            // table entries always walk the small path
            large_page_path <= page_size_extension_control &
               entry_from_dir & page_next.large_page_flag;
            small_page_path <= ~(page_size_extension_control &
               entry_from_dir & page_next.large_page_flag);
         end
      end
   end

   // application type decode
   always_comb begin
      app_next.is_code = desc_type[`DFD_DT_CODE];
      app_next.writable = ~desc_type[`DFD_DT_CODE] &
         desc_type[`DFD_DT_RW];
      // data segments are always readable
      app_next.readable = ~desc_type[`DFD_DT_CODE] |
         desc_type[`DFD_DT_RW];
      app_next.expand_down = ~desc_type[`DFD_DT_CODE] &
         desc_type[`DFD_DT_EXP];
      app_next.conforming = desc_type[`DFD_DT_CODE] &
         desc_type[`DFD_DT_EXP];
      app_next.accessed = desc_type[`DFD_DT_ACC];
   end

   // system segment and gate type decode
   always_comb begin
      case (desc_type)
         `DFD_SYS_TASK16_FREE: kind_next = DFD_SK_TASK16_FREE;
         `DFD_SYS_LOCAL_TABLE: kind_next = DFD_SK_LOCAL_TABLE;
         `DFD_SYS_TASK16_BUSY: kind_next = DFD_SK_TASK16_BUSY;
         `DFD_SYS_TASK32_FREE: kind_next = DFD_SK_TASK32_FREE;
         `DFD_SYS_TASK32_BUSY: kind_next = DFD_SK_TASK32_BUSY;
         `DFD_SYS_CALL16: kind_next = DFD_SK_CALL16;
         `DFD_SYS_CALL32: kind_next = DFD_SK_CALL32;
         `DFD_SYS_TASK_GATE: kind_next = DFD_SK_TASK_GATE;
         `DFD_SYS_INT16: kind_next = DFD_SK_INT16;
         `DFD_SYS_INT32: kind_next = DFD_SK_INT32;
         `DFD_SYS_TRAP16: kind_next = DFD_SK_TRAP16;
         `DFD_SYS_TRAP32: kind_next = DFD_SK_TRAP32;
         default: kind_next = DFD_SK_RESERVED;
      endcase
   end

   // latched descriptor decode; the unused view reads as zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         app_fields <= '0;
         sys_kind <= DFD_SK_RESERVED;
         desc_valid <= 1'b0;
      end else begin
         desc_valid <= desc_load;
         if (desc_load) begin
            app_fields <= desc_is_app ? app_next : '0;
            sys_kind <= desc_is_app ? DFD_SK_RESERVED : kind_next;
         end
      end
   end

   // a level change without a gate is refused
   assign xfer_refused = xfer_req & (xfer_cur_pl != xfer_tgt_pl) &
      ~xfer_via_gate;

   // transfer verdict, held until the next request
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         xfer_ok <= 1'b0;
         xfer_done <= 1'b0;
      end else begin
         xfer_done <= xfer_req;
         if (xfer_req) begin
            xfer_ok <= ~xfer_refused;
         end
      end
   end

   // hardware vector select, lowest number first
   // present flags and a violation without a reference are only
   // qualifiers and raise nothing on their own
   always_comb begin
      hw_hit = 1'b1;
      hw_vec = `DFD_V_PROTECT;
      if (fault_in.divide_err) begin
         hw_vec = `DFD_V_DIVIDE;
      end else if (fault_in.debug_hit) begin
         hw_vec = `DFD_V_DEBUG;
      end else if (fault_in.breakpoint) begin
         hw_vec = `DFD_V_BREAK;
      end else if (fault_in.overflow) begin
         hw_vec = `DFD_V_OVERFLOW;
      end else if (fault_in.bound_err) begin
         hw_vec = `DFD_V_BOUND;
      end else if (fault_in.bad_opcode) begin
         hw_vec = `DFD_V_OPCODE;
      end else if (fault_in.no_device) begin
         hw_vec = `DFD_V_NO_DEVICE;
      end else if (fault_in.bad_task_seg) begin
         hw_vec = `DFD_V_BAD_TASK;
      end else if (fault_in.seg_load & ~fault_in.seg_present) begin
         hw_vec = `DFD_V_NOT_PRESENT;
      end else if (fault_in.stack_limit |
            (fault_in.stack_ref & ~fault_in.stack_present)) begin
         hw_vec = `DFD_V_STACK;
      end else if (fault_in.misc_protect | xfer_refused) begin
         hw_vec = `DFD_V_PROTECT;
      end else if (fault_in.page_ref &
            (fault_in.page_violation | ~page_fields.present)) begin
         hw_vec = `DFD_V_PAGE;
      end else if (fault_in.float_err) begin
         hw_vec = `DFD_V_FLOAT;
      end else if (fault_in.unaligned & alignment_check_flag &
            alignment_mask_bit) begin
         hw_vec = `DFD_V_ALIGN;
      end else begin
         hw_hit = 1'b0;
      end
   end

   // nmi outranks faults, faults outrank software requests
   always_comb begin
      take_double = hw_hit & (state_reg == DFD_DELIVER);
      raise = nmi_rise | hw_hit | soft_int;
      if (nmi_rise) begin
         vec_next = `DFD_V_NMI;
      end else if (take_double) begin
         vec_next = `DFD_V_DOUBLE;
      end else if (hw_hit) begin
         vec_next = hw_vec;
      end else begin
         vec_next = soft_vec;
      end
   end

   // delivery tracking; a new raise wins over deliver_done
   // nmi and software requests enter here too, so a fault that follows
   // either of them is also taken as a double fault
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= DFD_IDLE;
      end else begin
         case (state_reg)
            DFD_IDLE: begin
               if (raise) begin
                  state_reg <= DFD_DELIVER;
               end
            end
            DFD_DELIVER: begin
               if (deliver_done & ~raise) begin
                  state_reg <= DFD_IDLE;
               end
            end
            default: state_reg <= DFD_IDLE;
         endcase
      end
   end

   // vector output: one pulse per raise, number held after it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         vec_valid <= 1'b0;
         vec_num <= 8'h00;
         delivering <= 1'b0;
         last_vec_reg <= 8'h00;
      end else begin
         vec_valid <= raise;
         delivering <= (state_reg == DFD_DELIVER) ?
            ~(deliver_done & ~raise) : raise;
         if (raise) begin
            vec_num <= vec_next;
            last_vec_reg <= vec_next;
         end
      end
   end

   // events that feed the sticky status bits
   always_comb begin
      event_set = '0;
      event_set[`DFD_ST_VEC] = raise;
      event_set[`DFD_ST_DOUBLE] = take_double & ~nmi_rise;
      event_set[`DFD_ST_NMI] = nmi_rise;
      event_set[`DFD_ST_XFER] = xfer_refused;
   end

   // control and mask registers
   // unused write data bits are dropped, unmapped writes land nowhere
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_reg <= `DFD_CTRL_RST;
         mask_reg <= `DFD_MASK_RST;
      end else if (reg_wr) begin
         if (reg_addr == `DFD_OFF_CTRL) begin
            ctrl_reg <= reg_wdata[1:0];
         end
         if (reg_addr == `DFD_OFF_MASK) begin
            mask_reg <= reg_wdata[`DFD_ST_W-1:0];
         end
      end
   end

   // sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_reg <= '0;
      end else if (reg_wr && reg_addr == `DFD_OFF_STATUS) begin
         status_reg <= (status_reg & ~reg_wdata[`DFD_ST_W-1:0]) |
            event_set;
      end else begin
         status_reg <= status_reg | event_set;
      end
   end

   // interrupt line follows the registered status next cycle
   // one cycle of latency buys an output straight from a flop
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_reg & mask_reg);
      end
   end

   // read port: data stand one cycle after the strobe only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `DFD_OFF_CTRL: reg_rdata <= {30'h0000_0000, ctrl_reg};
            `DFD_OFF_STATUS: reg_rdata <= {28'h000_0000, status_reg};
            `DFD_OFF_MASK: reg_rdata <= {28'h000_0000, mask_reg};
            // busy flag sits just above the last vector number
            `DFD_OFF_LAST: begin
               reg_rdata <= {23'h00_0000,
                  state_reg == DFD_DELIVER, last_vec_reg};
            end
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule

// *** dfd_decode_asserts.sv ***
// concurrent checks for the descriptor and fault decode block
// assumes binding onto dfd_decode, one clock, synchronous reset
`timescale 1ns/1ns
module dfd_decode_asserts
   import dfd_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic entry_load,
   input wire logic [31:0] entry_data,
   input wire logic entry_from_dir,
   input wire dfd_page_t page_fields,
   input wire logic large_page_path,
   input wire logic small_page_path,
   input wire logic page_valid,
   input wire logic desc_load,
   input wire logic desc_is_app,
   input wire logic [3:0] desc_type,
   input wire dfd_app_t app_fields,
   input wire dfd_sys_kind_t sys_kind,
   input wire logic desc_valid,
   input wire logic xfer_req,
   input wire logic [1:0] xfer_cur_pl,
   input wire logic [1:0] xfer_tgt_pl,
   input wire logic xfer_via_gate,
   input wire logic xfer_ok,
   input wire logic xfer_done,
   input wire dfd_fault_t fault_in,
   input wire logic alignment_check_flag,
   input wire logic soft_int,
   input wire logic deliver_done,
   input wire logic vec_valid,
   input wire logic [7:0] vec_num,
   input wire logic delivering
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // expected application type decode, data always readable
   function automatic dfd_app_t app_exp(input logic [3:0] t);
      app_exp = {t[3], !t[3] && t[1], !t[3] || t[1], !t[3] && t[2],
         t[3] && t[2], t[0]};
   endfunction

   chk_page_bits: assert property (
      entry_load |=> page_valid && page_fields == {$past(entry_data[0]),
      $past(entry_data[1]), $past(entry_data[2]), $past(entry_data[3]),
      $past(entry_data[4]), $past(entry_data[5]), $past(entry_data[7]),
      $past(entry_data[11:9])})
      else $error("paging entry fields misplaced");
   chk_small_path: assert property (
      entry_load && !(entry_from_dir && entry_data[7])
      |=> small_page_path && !large_page_path)
      else $error("large path taken without large flag");
   chk_app_decode: assert property (
      desc_load && desc_is_app
      |=> desc_valid && app_fields == app_exp($past(desc_type)))
      else $error("application type decode wrong");
   chk_sys_reserved: assert property (
      desc_load && (desc_is_app || desc_type inside {4'h0, 4'h8, 4'ha,
      4'hd}) |=> sys_kind == DFD_SK_RESERVED)
      else $error("reserved system type not reserved");
   chk_xfer_gate: assert property (
      xfer_req |=> xfer_done && xfer_ok == ($past(xfer_via_gate) ||
      $past(xfer_cur_pl) == $past(xfer_tgt_pl)))
      else $error("privilege change allowed without gate");
   chk_divide_vec: assert property (
      fault_in.divide_err && !delivering |=> vec_valid && vec_num == 8'h00)
      else $error("divide error vector wrong");
   chk_double_vec: assert property (
      fault_in.misc_protect && delivering && !deliver_done
      |=> vec_valid && vec_num == 8'h08)
      else $error("no double fault during delivery");
   chk_align_off: assert property (
      fault_in == 18'h1 && !alignment_check_flag && !soft_int && !delivering
      && !xfer_req |=> !vec_valid)
      else $error("alignment vector raised while disabled");
   chk_hw_vector: assert property (
      vec_valid && !$past(soft_int) |-> vec_num != 8'h0f && vec_num != 8'h09)
      else $error("reserved vector raised by hardware");

   // main scenarios reached
   cover property (vec_valid && vec_num == 8'h08);
   cover property (entry_load ##1 large_page_path);
   cover property (xfer_done && !xfer_ok);
endmodule

// *** tb_dfd_decode.sv ***
// self-checking bench for the descriptor and fault decode block
// assumes dfd_pkg and dfd_decode_asserts are compiled first
`timescale 1ns/1ns
module tb_dfd_decode
   import dfd_pkg::*;
;
   logic clk, sys_rst, reg_wr, reg_rd, irq, entry_load, entry_from_dir;
   logic page_valid, large_page_path, small_page_path, desc_load;
   logic desc_is_app, desc_valid, xfer_req, xfer_via_gate, xfer_ok;
   logic xfer_done, nmi_pin, alignment_check_flag, soft_int;
   logic deliver_done, vec_valid, delivering;
   logic [3:0] reg_addr, desc_type;
   logic [31:0] reg_wdata, reg_rdata, entry_data, d;
   logic [1:0] xfer_cur_pl, xfer_tgt_pl;
   logic [7:0] soft_vec, vec_num;
   dfd_fault_t fault_in;
   dfd_page_t page_fields;
   dfd_app_t app_fields;
   dfd_sys_kind_t sys_kind;
   dfd_sys_kind_t stab [16];
   logic [7:0] vtab [18];
   int fails, comparisons;

   dfd_decode u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .entry_load(entry_load),
      .entry_data(entry_data), .entry_from_dir(entry_from_dir),
      .page_fields(page_fields), .large_page_path(large_page_path),
      .small_page_path(small_page_path), .page_valid(page_valid),
      .desc_load(desc_load), .desc_is_app(desc_is_app),
      .desc_type(desc_type), .app_fields(app_fields), .sys_kind(sys_kind),
      .desc_valid(desc_valid), .xfer_req(xfer_req),
      .xfer_cur_pl(xfer_cur_pl), .xfer_tgt_pl(xfer_tgt_pl),
      .xfer_via_gate(xfer_via_gate), .xfer_ok(xfer_ok),
      .xfer_done(xfer_done), .fault_in(fault_in), .nmi_pin(nmi_pin),
      .alignment_check_flag(alignment_check_flag), .soft_int(soft_int),
      .soft_vec(soft_vec), .deliver_done(deliver_done),
      .vec_valid(vec_valid), .vec_num(vec_num), .delivering(delivering));

   // 250 MHz core clock
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task end_sim;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // register port: one-cycle strobes, read data the cycle after
   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask

   task rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 v = reg_rdata;
   endtask

   // one-cycle fault or software request, vector seen the cycle after
   task fire(input dfd_fault_t f, input logic s, input logic [7:0] sv,
      input logic [7:0] v);
      @(posedge clk);
      fault_in <= f;
      soft_int <= s;
      soft_vec <= sv;
      @(posedge clk);
      fault_in <= 18'h0;
      soft_int <= 1'h0;
      #1 chk("vec_valid", vec_valid, 32'h1);
      chk("vec_num", vec_num, v);
      chk("delivering", delivering, 32'h1);
   endtask

   task done;
      @(posedge clk);
      deliver_done <= 1'h1;
      @(posedge clk);
      deliver_done <= 1'h0;
      #1 chk("delivering", delivering, 32'h0);
   endtask

   task ld_page(input logic [31:0] v, input logic dir, input logic lg);
      @(posedge clk);
      entry_load <= 1'h1;
      entry_data <= v;
      entry_from_dir <= dir;
      @(posedge clk);
      entry_load <= 1'h0;
      #1 chk("page_valid", page_valid, 32'h1);
      chk("page_fields", page_fields,
         {v[0], v[1], v[2], v[3], v[4], v[5], v[7], v[11:9]});
      chk("large_page_path", large_page_path, lg);
      chk("small_page_path", small_page_path, !lg);
   endtask

   task ld_desc(input logic app, input logic [3:0] t);
      @(posedge clk);
      desc_load <= 1'h1;
      desc_is_app <= app;
      desc_type <= t;
      @(posedge clk);
      desc_load <= 1'h0;
      #1 chk("desc_valid", desc_valid, 32'h1);
      if (app)
         chk("app_fields", app_fields, {t[3], !t[3] && t[1],
            !t[3] || t[1], !t[3] && t[2], t[3] && t[2], t[0]});
      else
         chk("sys_kind", sys_kind, stab[t]);
   endtask

   task xfer(input logic [1:0] c, input logic [1:0] g, input logic gt);
      @(posedge clk);
      xfer_req <= 1'h1;
      xfer_cur_pl <= c;
      xfer_tgt_pl <= g;
      xfer_via_gate <= gt;
      @(posedge clk);
      xfer_req <= 1'h0;
      #1 chk("xfer_done", xfer_done, 32'h1);
      chk("xfer_ok", xfer_ok, (c == g) || gt);
   endtask

   // watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      end_sim;
   end

   // main sequence
   initial begin
      {reg_wr, reg_rd, entry_load, entry_from_dir, desc_load} = 5'h0;
      {desc_is_app, xfer_req, xfer_via_gate, nmi_pin} = 4'h0;
      {alignment_check_flag, soft_int, deliver_done} = 3'h0;
      {reg_addr, desc_type, xfer_cur_pl, xfer_tgt_pl} = 12'h0;
      {reg_wdata, entry_data, soft_vec} = 72'h0;
      fault_in = 18'h0;
      sys_rst = 1'h1;
      stab = '{DFD_SK_RESERVED, DFD_SK_TASK16_FREE, DFD_SK_LOCAL_TABLE,
         DFD_SK_TASK16_BUSY, DFD_SK_CALL16, DFD_SK_TASK_GATE, DFD_SK_INT16,
         DFD_SK_TRAP16, DFD_SK_RESERVED, DFD_SK_TASK32_FREE,
         DFD_SK_RESERVED, DFD_SK_TASK32_BUSY, DFD_SK_CALL32,
         DFD_SK_RESERVED, DFD_SK_INT32, DFD_SK_TRAP32};
      // indexed by fault_in bit, ff marks a level qualifier
      vtab = '{8'h11, 8'h10, 8'hff, 8'h0e, 8'h0d, 8'hff, 8'h0c, 8'h0c,
         8'hff, 8'h0b, 8'h0a, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h01,
         8'h00};
      repeat (8) @(posedge clk);
      sys_rst <= 1'h0;
      for (int a = 0; a < 16; a += 4) begin
         rd(a[3:0], d);
         chk("reset value", d, 32'h0);
      end
      // alignment fault ignored while disabled
      @(posedge clk);
      fault_in <= 18'h1;
      @(posedge clk);
      fault_in <= 18'h0;
      #1 chk("vec_valid", vec_valid, 32'h0);
      wr(4'h0, 32'h2);
      alignment_check_flag <= 1'h1;
      for (int i = 0; i < 18; i++) begin
         if (vtab[i] != 8'hff) begin
            fire(18'h1<<i, 1'h0, 8'h0, vtab[i]);
            done;
         end
      end
      // sticky status, mask, irq, write-one clear, unmapped place
      rd(4'h4, d);
      chk("status", d, 32'h1);
      chk("irq", irq, 32'h0);
      wr(4'h8, 32'h1);
      @(posedge clk);
      #1 chk("irq", irq, 32'h1);
      wr(4'h4, 32'h1);
      @(posedge clk);
      #1 chk("irq", irq, 32'h0);
      wr(4'h2, 32'hffffffff);
      rd(4'h2, d);
      chk("unmapped", d, 32'h0);
      rd(4'h0, d);
      chk("ctrl", d, 32'h2);
      // second fault while the first is still outstanding
      fire(18'h20000, 1'h0, 8'h0, 8'h00);
      fire(18'h10, 1'h0, 8'h0, 8'h08);
      rd(4'hc, d);
      chk("last", d, 32'h108);
      done;
      rd(4'h4, d);
      chk("status", d, 32'h3);
      // nmi passes a synchroniser, so allow a few cycles
      @(posedge clk);
      nmi_pin <= 1'h1;
      repeat (10) begin
         @(posedge clk);
         #1 if (vec_valid === 1'h1) break;
      end
      chk("vec_valid", vec_valid, 32'h1);
      chk("vec_num", vec_num, 32'h2);
      @(posedge clk);
      nmi_pin <= 1'h0;
      done;
      // software may pick any vector but loses to a fault
      fire(18'h0, 1'h1, 8'h0f, 8'h0f);
      done;
      fire(18'h0, 1'h1, 8'hff, 8'hff);
      done;
      fire(18'h20000, 1'h1, 8'h0f, 8'h00);
      done;
      // paging entry decode and path choice
      wr(4'h0, 32'h3);
      ld_page(32'heaf, 1'h1, 1'h1);
      ld_page(32'heaf, 1'h0, 1'h0);
      ld_page(32'h150, 1'h1, 1'h0);
      wr(4'h0, 32'h2);
      ld_page(32'heaf, 1'h1, 1'h0);
      // violation on a present page still faults
      fire(18'hc, 1'h0, 8'h0, 8'h0e);
      done;
      for (int i = 0; i < 32; i++)
         ld_desc(i[4], i[3:0]);
      // refused privilege change raises the protection vector
      xfer(2'h0, 2'h3, 1'h0);
      chk("vec_valid", vec_valid, 32'h1);
      chk("vec_num", vec_num, 32'h0d);
      done;
      for (int i = 0; i < 32; i++)
         xfer(i[1:0], i[3:2], i[4]);
      done;
      rd(4'h4, d);
      chk("status", d, 32'hf);
      end_sim;
   end
endmodule

bind dfd_decode dfd_decode_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
   .entry_load(entry_load), .entry_data(entry_data),
   .entry_from_dir(entry_from_dir), .page_fields(page_fields),
   .large_page_path(large_page_path), .small_page_path(small_page_path),
   .page_valid(page_valid), .desc_load(desc_load),
   .desc_is_app(desc_is_app), .desc_type(desc_type),
   .app_fields(app_fields), .sys_kind(sys_kind), .desc_valid(desc_valid),
   .xfer_req(xfer_req), .xfer_cur_pl(xfer_cur_pl),
   .xfer_tgt_pl(xfer_tgt_pl), .xfer_via_gate(xfer_via_gate),
   .xfer_ok(xfer_ok), .xfer_done(xfer_done), .fault_in(fault_in),
   .alignment_check_flag(alignment_check_flag), .soft_int(soft_int),
   .deliver_done(deliver_done), .vec_valid(vec_valid),
   .vec_num(vec_num), .delivering(delivering));
